// >>> inc/rx_queue_params.svh
// constants for the receive queue water mark and frame count registers
`ifndef RX_QUEUE_PARAMS_SVH
`define RX_QUEUE_PARAMS_SVH
`define LOW_MARK_OFFSET 12'h1B0
`define HIGH_MARK_OFFSET 12'h1B2
`define OVERRUN_MARK_OFFSET 12'h1B4
`define FRAME_COUNT_OFFSET 12'h1B8
`define LOW_MARK_RESET 12'h600
`define HIGH_MARK_RESET 12'h400
`define OVERRUN_MARK_RESET 12'h040
`define FRAME_COUNT_RESET 8'h00
`define MARK_MSB 11
`define COUNT_LSB 8
`define RX_IRQ_BIT 13
`endif

// >>> inc/rx_queue_pkg.sv
// types for the receive queue water mark block
package rx_queue_pkg;
  typedef enum logic [2:0] {
    FLOW_OPEN = 3'b001,
    FLOW_PAUSE = 3'b010,
    FLOW_DROP = 3'b100
  } flow_state_e;
  typedef logic [11:0] mark_t;
endpackage

// >>> src/frame_count_capture.sv
// latch of pending frame count on receive interrupt acknowledge
`timescale 1ns/1ps
`include "rx_queue_params.svh"
module frame_count_capture #(
  parameter int COUNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // capture request and live count
  input wire logic capture,
  input wire logic [COUNT_W-1:0] live_count,
  // held count
  output logic [COUNT_W-1:0] held_count
);
  typedef struct packed {
    logic [COUNT_W-1:0] count;
  } cap_s;
  cap_s st_reg;
  cap_s st_next;

  always_comb begin
    st_next = st_reg;
    if (capture) begin
      st_next.count = live_count;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign held_count = st_reg.count;

  capture_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    capture |=> held_count == $past(live_count))
    else $error("frame count not captured");
  count_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !capture |=> $stable(held_count))
    else $error("frame count changed without capture");
endmodule

// >>> src/rx_queue_flow_watermarks.sv
// receive queue water marks, flow control and pending frame count
`timescale 1ns/1ps
`include "rx_queue_params.svh"
module rx_queue_flow_watermarks
  import rx_queue_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int COUNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // host register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // receive queue status
  input wire logic [11:0] free_words,
  input wire logic [COUNT_W-1:0] pending_frame_count,
  input wire logic rx_irq_pending,
  input wire logic irq_status_write,
  input wire logic [15:0] irq_status_wdata,
  // flow control outputs
  output logic rx_flow_pause,
  output logic rx_drop
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    mark_t low_mark;
    mark_t high_mark;
    mark_t overrun_mark;
    logic [15:0] rdata;
    flow_state_e flow;
  } state_s;
  state_s st_reg;
  state_s st_next;
  logic capture;
  logic [COUNT_W-1:0] held_count;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction

  // ack of receive interrupt: write one to bit 13 while it is raised
  assign capture = irq_status_write && irq_status_wdata[`RX_IRQ_BIT] && rx_irq_pending;

  frame_count_capture #(
    .COUNT_W(COUNT_W)
  ) u_capture (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .capture(capture),
    .live_count(pending_frame_count),
    .held_count(held_count)
  );

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (reg_wr) begin
      if (hit(reg_addr, `LOW_MARK_OFFSET)) begin
        st_next.low_mark = reg_wdata[`MARK_MSB:0];
      end else if (hit(reg_addr, `HIGH_MARK_OFFSET)) begin
        st_next.high_mark = reg_wdata[`MARK_MSB:0];
      end else if (hit(reg_addr, `OVERRUN_MARK_OFFSET)) begin
        st_next.overrun_mark = reg_wdata[`MARK_MSB:0];
      end
    end
    // reserved bits read zero; count field is read only
    st_next.rdata = 16'h0000;
    if (reg_rd) begin
      if (hit(reg_addr, `LOW_MARK_OFFSET)) begin
        st_next.rdata = {4'h0, st_reg.low_mark};
      end else if (hit(reg_addr, `HIGH_MARK_OFFSET)) begin
        st_next.rdata = {4'h0, st_reg.high_mark};
      end else if (hit(reg_addr, `OVERRUN_MARK_OFFSET)) begin
        st_next.rdata = {4'h0, st_reg.overrun_mark};
      end else if (hit(reg_addr, `FRAME_COUNT_OFFSET)) begin
        st_next.rdata = {held_count[7:0], `FRAME_COUNT_RESET};
      end
    end
    // hysteresis: a gap between marks prevents pause chatter
    case (st_reg.flow)
      FLOW_OPEN: begin
        if (free_words < st_reg.overrun_mark) begin
          st_next.flow = FLOW_DROP;
        end else if (free_words < st_reg.high_mark) begin
          st_next.flow = FLOW_PAUSE;
        end
      end
      FLOW_PAUSE: begin
        if (free_words < st_reg.overrun_mark) begin
          st_next.flow = FLOW_DROP;
        end else if (free_words > st_reg.low_mark) begin
          st_next.flow = FLOW_OPEN;
        end
      end
      FLOW_DROP: begin
        if (free_words >= st_reg.overrun_mark) begin
          st_next.flow = (free_words > st_reg.low_mark) ? FLOW_OPEN : FLOW_PAUSE;
        end
      end
      default: begin
        st_next.flow = FLOW_OPEN;
      end
    endcase
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg.low_mark <= `LOW_MARK_RESET;
      st_reg.high_mark <= `HIGH_MARK_RESET;
      st_reg.overrun_mark <= `OVERRUN_MARK_RESET;
      st_reg.rdata <= 16'h0000;
      st_reg.flow <= FLOW_OPEN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign rx_flow_pause = (st_reg.flow != FLOW_OPEN);
  assign rx_drop = (st_reg.flow == FLOW_DROP);

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  low_mark_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr == `LOW_MARK_OFFSET |=> st_reg.low_mark == $past(reg_wdata[11:0]))
    else $error("low mark not written");
  high_mark_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr == `HIGH_MARK_OFFSET |=> st_reg.high_mark == $past(reg_wdata[11:0]))
    else $error("high mark not written");
  overrun_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr == `OVERRUN_MARK_OFFSET |=> st_reg.overrun_mark == $past(reg_wdata[11:0]))
    else $error("overrun mark not written");
  count_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `FRAME_COUNT_OFFSET && !capture |=> reg_rdata[15:8] == held_count)
    else $error("frame count readback wrong");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && (reg_addr == `LOW_MARK_OFFSET || reg_addr == `HIGH_MARK_OFFSET
      || reg_addr == `OVERRUN_MARK_OFFSET) |=> reg_rdata[15:12] == 4'h0)
    else $error("mark reserved bits not zero");
  count_low_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `FRAME_COUNT_OFFSET |=> reg_rdata[7:0] == 8'h00)
    else $error("frame count low byte not zero");
  low_mark_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `LOW_MARK_OFFSET |=> reg_rdata == {4'h0, $past(st_reg.low_mark)})
    else $error("low mark readback wrong");
  high_mark_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `HIGH_MARK_OFFSET |=> reg_rdata == {4'h0, $past(st_reg.high_mark)})
    else $error("high mark readback wrong");
  overrun_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `OVERRUN_MARK_OFFSET |=> reg_rdata == {4'h0, $past(st_reg.overrun_mark)})
    else $error("overrun mark readback wrong");
  // read data is a one-cycle answer; a stale word would be mistaken for a new read
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not back to zero");
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr != `LOW_MARK_OFFSET && reg_addr != `HIGH_MARK_OFFSET
      && reg_addr != `OVERRUN_MARK_OFFSET && reg_addr != `FRAME_COUNT_OFFSET
      |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // -------------------------------------------------------------
  // flow control checks
  // -------------------------------------------------------------
  pause_entry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_reg.flow == FLOW_OPEN && free_words < st_reg.high_mark |=> rx_flow_pause)
    else $error("pause not raised below high mark");
  pause_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_reg.flow == FLOW_PAUSE && free_words > st_reg.low_mark && free_words >= st_reg.overrun_mark
      |=> !rx_flow_pause)
    else $error("pause not released above low mark");
  drop_entry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    free_words < st_reg.overrun_mark |=> rx_drop)
    else $error("drop not raised below overrun mark");
  // drop leaves at once on recovery; pause may still stand for hysteresis
  drop_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_reg.flow == FLOW_DROP && free_words >= st_reg.overrun_mark |=> !rx_drop)
    else $error("drop not released at overrun mark");

  pause_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(rx_flow_pause));
  drop_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(rx_drop));
  capture_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) capture);
  release_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) $fell(rx_flow_pause));
endmodule

// >>> test/host_model.sv
// host processor model for the register port
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [11:0] reg_addr = 12'h000,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [15:0] reg_wdata = 16'h0000,
  input wire logic [15:0] reg_rdata
);
  // one-cycle strobe, held request until the sampling edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // released data shows no stale value
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// >>> test/rx_queue_flow_watermarks_tb.sv
// self-checking bench for the receive queue water mark block
`timescale 1ns/1ps
module rx_queue_flow_watermarks_tb;
  import rx_queue_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] reg_addr, f;
  logic reg_wr, reg_rd, rx_flow_pause, rx_drop, p;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [15:0] irq_status_wdata = 16'h0000;
  logic [15:0] lfsr = 16'h004F;
  logic [11:0] free_words = 12'hFFF;
  logic [7:0] pending_frame_count = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic rx_irq_pending = 1'b0;
  logic irq_status_write = 1'b0;
  logic [11:0] addrs [4] = '{12'h1B0, 12'h1B2, 12'h1B4, 12'h1B8};
  logic [15:0] rstv [4] = '{16'h0600, 16'h0400, 16'h0040, 16'h0000};
  logic [11:0] corner [6] = '{12'h03F, 12'h040, 12'h3FF, 12'h400, 12'h600, 12'h601};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  rx_queue_flow_watermarks i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .free_words(free_words),
    .pending_frame_count(pending_frame_count), .rx_irq_pending(rx_irq_pending),
    .irq_status_write(irq_status_write), .irq_status_wdata(irq_status_wdata),
    .rx_flow_pause(rx_flow_pause), .rx_drop(rx_drop));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // hysteresis: pause below high mark, kept until above low mark
  function automatic logic exp_pause(input logic q, input logic [11:0] v);
    return (v < 12'h400) ? 1'b1 : (v > 12'h600) ? 1'b0 : q;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // run is under two hundred cycles; cut off well beyond
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_host.rd(addrs[i], d);
      check(d, rstv[i]);
    end
    for (int i = 0; i < 12; i++) begin
      lfsr = rnd(lfsr);
      i_host.wr(addrs[i % 3], lfsr);
      i_host.rd(addrs[i % 3], d);
      check(d, {4'h0, lfsr[11:0]});
    end
    i_host.wr(12'h1B8, 16'hFFFF);
    i_host.rd(12'h1B8, d);
    check(d, 16'h0000);
    i_host.rd(12'h1BA, d);
    check(d, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      i_host.wr(addrs[i], rstv[i]);
    end
    // last two rounds: no pending interrupt, then bit 13 clear
    for (int i = 0; i < 6; i++) begin
      lfsr = rnd(lfsr);
      cnt = (i >= 4) ? cnt : lfsr[7:0];
      @(posedge ref_clk);
      pending_frame_count <= lfsr[7:0];
      rx_irq_pending <= (i != 4);
      irq_status_write <= 1'b1;
      irq_status_wdata <= (i == 5) ? 16'hDFFF : 16'h2000;
      @(posedge ref_clk);
      irq_status_write <= 1'b0;
      pending_frame_count <= ~lfsr[7:0];
      // count read comes after the live count has already changed
      i_host.rd(12'h1B8, d);
      check(d, {cnt, 8'h00});
    end
    p = 1'b0;
    for (int i = 0; i < 40; i++) begin
      lfsr = rnd(lfsr);
      f = (i < 6) ? corner[i] : (i % 4 == 0) ? {6'h00, lfsr[5:0]} : lfsr[11:0];
      @(posedge ref_clk);
      free_words <= f;
      @(posedge ref_clk);
      #1 p = exp_pause(p, f);
      check({14'h0000, rx_drop, rx_flow_pause}, {14'h0000, f < 12'h040, p});
    end
    close_out();
  end
endmodule
